// [core/fir_coef_pkg.sv]
// Constants, types and helpers for the channel-A FIR coefficient bank
//
// Behaviour
// - Tap two: 12-bit signed, offset 0x41C.
// - Tap three: 12-bit signed, offset 0x41E.
// - Center tap: 18-bit signed, offset 0x420.
// - Tap five: 12-bit signed, offset 0x423.
// - Coefficient MSB always reads back zero.
// - All coefficient bits reset to zero.
// - Offset 0x425 holds signed tap six.
// - Mode 2 enables filter, others disable.
// - Side LSB exponent is setting+16, setting clamped to six.
package fir_coef_pkg;

	// ****************************************
	// Bus widths
	// ****************************************
	localparam int ADDR_W = 12;
	localparam int DATA_W = 8;

	// ****************************************
	// Byte offsets
	// ****************************************
	localparam logic [11:0] CONFIG_OFS = 12'h400;
	localparam logic [11:0] TAP2_OFS   = 12'h41C;
	localparam logic [11:0] TAP3_OFS   = 12'h41E;
	localparam logic [11:0] CENTER_OFS = 12'h420;
	localparam logic [11:0] TAP5_OFS   = 12'h423;
	localparam logic [11:0] TAP6_OFS   = 12'h425;

	// ****************************************
	// Register sizes and field layouts
	// ****************************************
	localparam int SIDE_BYTES   = 2;
	localparam int CENTER_BYTES = 3;
	localparam int CONFIG_BYTES = 1;
	localparam int SIDE_W       = 12;
	localparam int CENTER_W     = 18;
	localparam int CONFIG_W     = 8;
	localparam int MODE_LSB     = 0;
	localparam int MODE_W       = 2;
	localparam int SCW_LSB      = 2;
	localparam int SCW_W        = 3;

	// ****************************************
	// Reset values and encodings
	// ****************************************
	localparam logic [15:0] SIDE_RST   = 16'h0000;
	localparam logic [23:0] CENTER_RST = 24'h000000;
	localparam logic [7:0]  CONFIG_RST = 8'h00;
	localparam logic [1:0]  MODE_OFF   = 2'h0;
	localparam logic [1:0]  MODE_ON    = 2'h2;
	localparam logic [2:0]  SCW_MAX    = 3'h6;
	localparam logic [4:0]  EXP_BIAS   = 5'h10;
	localparam logic [7:0]  RD_IDLE    = 8'h00;

	// Register port request, one cycle
	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic              wr;
		logic              rd;
	} bus_req_t;

	// Byte position of an address inside a register, all ones when outside
	function automatic logic [1:0] byte_index(input logic [11:0] addr,
		input logic [11:0] base, input int nbytes);
		logic [11:0] rel;
		rel = addr - base;
		if (addr >= base && rel < 12'(nbytes)) begin
			byte_index = rel[1:0];
		end else begin
			byte_index = 2'h3;
		end
	endfunction

endpackage

// [core/coef_reg.sv]
// Byte-writable coefficient register with masked readback
module coef_reg
	import fir_coef_pkg::*;
#(
	parameter logic [11:0] BASE     = 12'h000,
	parameter int          NBYTES   = 2,
	parameter int          FIELD_W  = 12,
	parameter bit          MASK_MSB = 1'b1,
	parameter logic [8*NBYTES-1:0] RST = '0
) (
	// Clock, reset, enable
	input  wire logic                  clk_in,
	input  wire logic                  rst_in,
	input  wire logic                  ce_in,
	// Register port
	input  wire bus_req_t              req_in,
	// Stored value and read byte
	output logic      [8*NBYTES-1:0]   value_out,
	output logic      [DATA_W-1:0]     rd_byte_out
);

	localparam int W = 8 * NBYTES;
	// Readback hides the coefficient MSB; stored value keeps it
	localparam logic [W-1:0] RD_MASK = MASK_MSB ? ~(W'(1) << (FIELD_W - 1)) : '1;

	// ****************************************
	// Decode
	// ****************************************
	wire logic [1:0]   idx   = byte_index(req_in.addr, BASE, NBYTES);
	wire logic         hit   = (idx != 2'h3);
	wire logic [W-1:0] shown = value_out & RD_MASK;

	assign rd_byte_out = hit ? shown[8*idx +: 8] : RD_IDLE;

	// ****************************************
	// Storage, one flop group per byte
	// ****************************************
	for (genvar i = 0; i < NBYTES; i++) begin : g_byte
		always_ff @(posedge clk_in or posedge rst_in) begin
			if (rst_in) begin
				value_out[8*i +: 8] <= RST[8*i +: 8];
			end else if (ce_in && req_in.wr && hit && idx == 2'(i)) begin
				value_out[8*i +: 8] <= req_in.wdata;
			end
		end
	end

endmodule

// [core/fir_coefficient_bank_a.sv]
// Channel-A FIR coefficient bank for taps two to six, with filter config
module fir_coefficient_bank_a
	import fir_coef_pkg::*;
(
	// Clock, reset, enable
	input  wire logic                clk_in,
	input  wire logic                rst_in,
	input  wire logic                ce_in,
	// Register port
	input  wire logic [ADDR_W-1:0]   addr_in,
	input  wire logic [DATA_W-1:0]   wdata_in,
	input  wire logic                wr_in,
	input  wire logic                rd_in,
	output logic      [DATA_W-1:0]   rdata_out,
	// Coefficients to the filter datapath
	output logic      [SIDE_W-1:0]   tap2_coef_out,
	output logic      [SIDE_W-1:0]   tap3_coef_out,
	output logic      [CENTER_W-1:0] center_coef_out,
	output logic      [SIDE_W-1:0]   tap5_coef_out,
	output logic      [SIDE_W-1:0]   tap6_coef_out,
	// Filter control
	output logic                     filter_enable_out,
	output logic      [4:0]          side_lsb_exp_out
);

	// ****************************************
	// Request bundle and register values
	// ****************************************
	wire bus_req_t req = '{addr: addr_in, wdata: wdata_in, wr: wr_in, rd: rd_in};

	logic [15:0]         tap2_value;
	logic [15:0]         tap3_value;
	logic [23:0]         center_value;
	logic [15:0]         tap5_value;
	logic [15:0]         tap6_value;
	logic [7:0]          config_value;
	logic [DATA_W-1:0]   tap2_rd, tap3_rd, center_rd, tap5_rd, tap6_rd, config_rd;
	logic [DATA_W-1:0]   rdata_q;
	logic                filter_enable_q;
	logic [4:0]          side_lsb_exp_q;

	// ****************************************
	// Coefficient registers
	// ****************************************
	// tap two register
	coef_reg #(.BASE(TAP2_OFS), .NBYTES(SIDE_BYTES), .FIELD_W(SIDE_W),
		.MASK_MSB(1'b1), .RST(SIDE_RST)) u_tap2 (
		.clk_in(clk_in), .rst_in(rst_in), .ce_in(ce_in), .req_in(req),
		.value_out(tap2_value), .rd_byte_out(tap2_rd));

	coef_reg #(.BASE(TAP3_OFS), .NBYTES(SIDE_BYTES), .FIELD_W(SIDE_W),
		.MASK_MSB(1'b1), .RST(SIDE_RST)) u_tap3 (
		.clk_in(clk_in), .rst_in(rst_in), .ce_in(ce_in), .req_in(req),
		.value_out(tap3_value), .rd_byte_out(tap3_rd));

	coef_reg #(.BASE(CENTER_OFS), .NBYTES(CENTER_BYTES), .FIELD_W(CENTER_W),
		.MASK_MSB(1'b1), .RST(CENTER_RST)) u_center (
		.clk_in(clk_in), .rst_in(rst_in), .ce_in(ce_in), .req_in(req),
		.value_out(center_value), .rd_byte_out(center_rd));

	coef_reg #(.BASE(TAP5_OFS), .NBYTES(SIDE_BYTES), .FIELD_W(SIDE_W),
		.MASK_MSB(1'b1), .RST(SIDE_RST)) u_tap5 (
		.clk_in(clk_in), .rst_in(rst_in), .ce_in(ce_in), .req_in(req),
		.value_out(tap5_value), .rd_byte_out(tap5_rd));

	coef_reg #(.BASE(TAP6_OFS), .NBYTES(SIDE_BYTES), .FIELD_W(SIDE_W),
		.MASK_MSB(1'b1), .RST(SIDE_RST)) u_tap6 (
		.clk_in(clk_in), .rst_in(rst_in), .ce_in(ce_in), .req_in(req),
		.value_out(tap6_value), .rd_byte_out(tap6_rd));

	// Config byte reads back whole, no hidden MSB
	coef_reg #(.BASE(CONFIG_OFS), .NBYTES(CONFIG_BYTES), .FIELD_W(CONFIG_W),
		.MASK_MSB(1'b0), .RST(CONFIG_RST)) u_config (
		.clk_in(clk_in), .rst_in(rst_in), .ce_in(ce_in), .req_in(req),
		.value_out(config_value), .rd_byte_out(config_rd));

	// ****************************************
	// Read path and filter control decode
	// ****************************************
	// Unselected registers give zero, so a plain OR merges them
	wire logic [DATA_W-1:0] rd_merge = tap2_rd | tap3_rd | center_rd | tap5_rd
		| tap6_rd | config_rd;
	wire logic [DATA_W-1:0] rdata_d  = rd_in ? rd_merge : RD_IDLE;

	wire logic [MODE_W-1:0] mode  = config_value[MODE_LSB +: MODE_W];
	wire logic [SCW_W-1:0]  scw   = config_value[SCW_LSB +: SCW_W];
	// Setting 7 is out of range; clamp so the datapath never sees it
	wire logic [SCW_W-1:0]  scw_c = (scw > SCW_MAX) ? SCW_MAX : scw;
	wire logic              filter_enable_d = (mode == MODE_ON);
	wire logic [4:0]        side_lsb_exp_d  = {2'h0, scw_c} + EXP_BIAS;

	// Output flops; control lags the config write by one cycle
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			rdata_q         <= RD_IDLE;
			filter_enable_q <= 1'b0;
			side_lsb_exp_q  <= EXP_BIAS;
		end else if (ce_in) begin
			rdata_q         <= rdata_d;
			filter_enable_q <= filter_enable_d;
			side_lsb_exp_q  <= side_lsb_exp_d;
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	assign rdata_out         = rdata_q;
	assign tap2_coef_out     = tap2_value[SIDE_W-1:0];
	assign tap3_coef_out     = tap3_value[SIDE_W-1:0];
	assign center_coef_out   = center_value[CENTER_W-1:0];
	assign tap5_coef_out     = tap5_value[SIDE_W-1:0];
	assign tap6_coef_out     = tap6_value[SIDE_W-1:0];
	assign filter_enable_out = filter_enable_q;
	assign side_lsb_exp_out  = side_lsb_exp_q;

	// ****************************************
	// Assertions
	// ****************************************
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (rst_in);

	wire logic wr_go = ce_in && wr_in;
	wire logic rd_go = ce_in && rd_in;

	a_tap2_low_write: assert property (wr_go && addr_in == TAP2_OFS |=>
		tap2_coef_out[7:0] == $past(wdata_in))
		else $error("tap two low byte not stored");

	a_tap3_high_write: assert property (wr_go && addr_in == TAP3_OFS + 12'h001 |=>
		tap3_coef_out[11:8] == $past(wdata_in[3:0]) && tap3_value[15:12] == $past(wdata_in[7:4]))
		else $error("tap three high byte not stored");

	a_center_top_write: assert property (wr_go && addr_in == CENTER_OFS + 12'h002 |=>
		center_coef_out[17:16] == $past(wdata_in[1:0]) && center_value[23:18] == $past(wdata_in[7:2]))
		else $error("center top byte not stored");

	a_tap5_low_write: assert property (wr_go && addr_in == TAP5_OFS |=>
		tap5_coef_out[7:0] == $past(wdata_in) && $stable(center_value))
		else $error("tap five write wrong or touched center");

	a_tap6_high_write: assert property (wr_go && addr_in == TAP6_OFS + 12'h001 |=>
		tap6_value[15:8] == $past(wdata_in))
		else $error("tap six high byte not stored");

	a_tap6_low_write: assert property (wr_go && addr_in == TAP6_OFS |=>
		tap6_coef_out[7:0] == $past(wdata_in) && $stable(tap5_value))
		else $error("tap six low byte not stored");

	a_msb_read_zero: assert property (rd_go && (addr_in == TAP2_OFS + 12'h001 ||
		addr_in == TAP6_OFS + 12'h001) |=> rdata_out[3] == 1'b0)
		else $error("side coefficient MSB visible on readback");

	a_center_msb_zero: assert property (rd_go && addr_in == CENTER_OFS + 12'h002 |=>
		rdata_out[1] == 1'b0 && rdata_out[7:2] == $past(center_value[23:18]))
		else $error("center readback wrong");

	a_reset_all_zero: assert property ($past(rst_in) |->
		tap2_value == 16'h0000 && tap3_value == 16'h0000 && center_value == 24'h000000
		&& tap5_value == 16'h0000 && tap6_value == 16'h0000 && !filter_enable_out)
		else $error("coefficient not zero after reset");

	a_mode_enable: assert property (wr_go && addr_in == CONFIG_OFS |-> ##2
		filter_enable_out == ($past(wdata_in[1:0], 2) == MODE_ON))
		else $error("filter enable does not follow mode");

	a_weight_exp: assert property (wr_go && addr_in == CONFIG_OFS && wdata_in[4:2] <= SCW_MAX
		|-> ##2 side_lsb_exp_out == {2'h0, $past(wdata_in[4:2], 2)} + EXP_BIAS)
		else $error("side weight exponent wrong");

	// Read data present one cycle only; a frozen clock enable holds it instead
	a_read_one_cycle: assert property (!rd_go |=>
		rdata_out == ($past(ce_in) ? RD_IDLE : $past(rdata_out)))
		else $error("read data outside read answer cycle");

	// tap three and five MSB hidden
	a_mid_msb_zero: assert property (rd_go && (addr_in == TAP3_OFS + 12'h001 ||
		addr_in == TAP5_OFS + 12'h001) |=> rdata_out[3] == 1'b0)
		else $error("tap three or five MSB visible on readback");

	a_tap2_reserved_kept: assert property (wr_go && addr_in == TAP2_OFS + 12'h001 |=>
		tap2_value[15:12] == $past(wdata_in[7:4]) && tap2_coef_out[11:8] == $past(wdata_in[3:0]))
		else $error("tap two high byte not stored");

	a_weight_clamp: assert property (wr_go && addr_in == CONFIG_OFS && wdata_in[4:2] > SCW_MAX
		|-> ##2 side_lsb_exp_out == {2'h0, SCW_MAX} + EXP_BIAS)
		else $error("side weight above six not clamped");

	// Clock enable low freezes every register and output
	a_ce_freeze: assert property (!ce_in |=> $stable(tap2_value) && $stable(tap3_value)
		&& $stable(center_value) && $stable(tap5_value) && $stable(tap6_value)
		&& $stable(config_value) && $stable(rdata_out) && $stable(filter_enable_out)
		&& $stable(side_lsb_exp_out))
		else $error("state changed while clock enable low");

	a_mode_reserved_off: assert property (wr_go && addr_in == CONFIG_OFS && wdata_in[0] |-> ##2
		!filter_enable_out)
		else $error("odd mode value enabled the filter");

	c_center_write_read: cover property (wr_go && addr_in == CENTER_OFS ##1 rd_go
		&& addr_in == CENTER_OFS);
	c_filter_on: cover property ($rose(filter_enable_out));
	c_tap6_signed: cover property (tap6_coef_out[11] && ce_in);
	c_weight_max: cover property (side_lsb_exp_out == 5'h16);
	c_mode_reserved: cover property (wr_go && addr_in == CONFIG_OFS
		&& wdata_in[1:0] == 2'h3);

endmodule

// [bench/tb.sv]
// Self-checking testbench for the channel-A FIR coefficient bank
`define CHK(nm, e, s) begin samples_checked++; if ((s) !== (e)) begin n_errors++; \
	$display("[ERR] %s expected %0h seen %0h", nm, e, s); end end
module tb import fir_coef_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;

	// ****************************************
	// Design hookup
	// ****************************************
	logic                clk_in, rst_in, ce_in, wr_in, rd_in;
	logic [ADDR_W-1:0]   addr_in;
	logic [DATA_W-1:0]   wdata_in, rdata_out;
	logic [SIDE_W-1:0]   tap2_coef_out, tap3_coef_out, tap5_coef_out, tap6_coef_out;
	logic [CENTER_W-1:0] center_coef_out;
	logic                filter_enable_out;
	logic [4:0]          side_lsb_exp_out;
	logic [7:0]          m [0:63];
	int                  n_errors, samples_checked, seed;

	fir_coefficient_bank_a fir_coefficient_bank_a_i (.clk_in, .rst_in, .ce_in, .addr_in,
		.wdata_in, .wr_in, .rd_in, .rdata_out, .tap2_coef_out, .tap3_coef_out,
		.center_coef_out, .tap5_coef_out, .tap6_coef_out, .filter_enable_out,
		.side_lsb_exp_out);

	// 50 MHz clock
	initial begin
		clk_in = 1'b0;
		forever #10 clk_in = ~clk_in;
	end

	// ****************************************
	// Expectation helpers
	// ****************************************
	function automatic bit mapped(input logic [11:0] a);
		return a == CONFIG_OFS || (a >= TAP2_OFS && a <= TAP6_OFS + 12'h001);
	endfunction

	// Readback byte: the sign bit of every coefficient reads as zero
	function automatic logic [7:0] exp_rd(input logic [11:0] a);
		logic [7:0] v;
		v = mapped(a) ? m[a[5:0]] : 8'h00;
		if (a inside {12'h41D, 12'h41F, 12'h424, 12'h426}) v[3] = 1'b0;
		if (a == 12'h422) v[1] = 1'b0;
		return v;
	endfunction

	// ****************************************
	// Bus tasks
	// ****************************************
	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		@(posedge clk_in);
		addr_in <= a;
		wdata_in <= d;
		wr_in <= 1'b1;
		@(posedge clk_in);
		wr_in <= 1'b0;
		if (mapped(a) && ce_in) m[a[5:0]] = d;
	endtask

	task automatic rd(input logic [11:0] a);
		@(posedge clk_in);
		addr_in <= a;
		rd_in <= 1'b1;
		@(posedge clk_in);
		rd_in <= 1'b0;
		@(negedge clk_in);
		`CHK("rdata", exp_rd(a), rdata_out)
		@(negedge clk_in);
		`CHK("rdata idle", 8'h00, rdata_out)
	endtask

	// Outputs settle two edges after the last write, config included
	task automatic chk_outs;
		@(posedge clk_in);
		@(negedge clk_in);
		`CHK("tap2", {m[6'h1D][3:0], m[6'h1C]}, tap2_coef_out)
		`CHK("tap3", {m[6'h1F][3:0], m[6'h1E]}, tap3_coef_out)
		`CHK("center", {m[6'h22][1:0], m[6'h21], m[6'h20]}, center_coef_out)
		`CHK("tap5", {m[6'h24][3:0], m[6'h23]}, tap5_coef_out)
		`CHK("tap6", {m[6'h26][3:0], m[6'h25]}, tap6_coef_out)
		`CHK("enable", m[0][1:0] == MODE_ON, filter_enable_out)
		`CHK("exponent", EXP_BIAS + 5'(m[0][4:2] > SCW_MAX ? SCW_MAX : m[0][4:2]),
			side_lsb_exp_out)
	endtask

	task automatic test_done;
		$display("checks %0d errors %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	// Watchdog, far beyond the roughly one thousand cycles the run needs
	initial begin
		#400000;
		n_errors++;
		test_done;
	end

	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		logic [11:0] a;
		rst_in = 1'b1;
		ce_in = 1'b1;
		wr_in = 1'b0;
		rd_in = 1'b0;
		addr_in = '0;
		wdata_in = '0;
		seed = 32'hf3903106;
		foreach (m[i]) m[i] = 8'h00;
		repeat (6) @(posedge clk_in);
		rst_in <= 1'b0;
		// Reset state, then a sweep across the map and its unmapped neighbours
		chk_outs;
		for (int i = 0; i < 42; i++) rd(12'h3FE + 12'(i));
		// All ones into every coefficient byte: sign bits masked, reserved bits kept
		for (int i = 0; i < 11; i++) begin
			wr(TAP2_OFS + 12'(i), 8'hFF);
			rd(TAP2_OFS + 12'(i));
		end
		chk_outs;
		// Every mode and weight setting, upper config bits random
		for (int i = 0; i < 32; i++) begin
			wr(CONFIG_OFS, 8'(i) | (8'($random(seed)) & 8'hE0));
			chk_outs;
		end
		// Back-to-back writes of both center low bytes
		@(posedge clk_in);
		addr_in <= CENTER_OFS;
		wdata_in <= 8'hA5;
		wr_in <= 1'b1;
		@(posedge clk_in);
		addr_in <= CENTER_OFS + 12'h001;
		wdata_in <= 8'h3C;
		@(posedge clk_in);
		wr_in <= 1'b0;
		m[6'h20] = 8'hA5;
		m[6'h21] = 8'h3C;
		chk_outs;
		// Random traffic over the bank and its edges
		repeat (300) begin
			a = ($random(seed) & 7) == 0 ? CONFIG_OFS : 12'h41B + 12'(($random(seed) & 15) % 13);
			if ($random(seed) & 1) wr(a, 8'($random(seed)));
			else rd(a);
		end
		chk_outs;
		// Frozen while the clock enable is low
		@(posedge clk_in);
		ce_in <= 1'b0;
		wr(TAP5_OFS, 8'h33);
		wr(CONFIG_OFS, 8'h0A);
		chk_outs;
		@(posedge clk_in);
		ce_in <= 1'b1;
		// Reset in mid-run clears everything
		@(posedge clk_in);
		rst_in <= 1'b1;
		@(posedge clk_in);
		rst_in <= 1'b0;
		foreach (m[i]) m[i] = 8'h00;
		chk_outs;
		for (int i = 0; i < 11; i++) rd(TAP2_OFS + 12'(i));
		test_done;
	end
endmodule
